// file: verilog/init_seq_pkg.sv
// constants shared by the phase 2 nibble sequencer and its buffer
`default_nettype none
package init_seq_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET       = 8'h00;
	localparam logic [7:0] STATUS_OFFSET     = 8'h04;
	localparam logic [7:0] USER_BASE_OFFSET  = 8'h10;
	localparam logic [7:0] SERIAL_OFFSET     = 8'h20;
	localparam logic [7:0] SERIAL_HI_OFFSET  = 8'h24;
	// control field positions
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_EXTEND_BIT = 1;
	localparam int CTRL_SELECT_BIT = 2;
	localparam int CTRL_ASYNC_BIT  = 3;
	localparam int CTRL_RETRY_LSB  = 4;
	// reset values
	localparam logic [3:0]  RETRY_LIMIT_RESET = 4'h2;
	localparam logic [31:0] DATA_RESET        = 32'h0000_0000;
	// data-block count field
	localparam logic [7:0] BLOCK_COUNT_BASE     = 8'h20;
	localparam logic [7:0] BLOCK_COUNT_EXTENDED = 8'h30;
	localparam logic [5:0] LAST_NIBBLE_BASE     = 6'h1f;
	localparam logic [5:0] LAST_NIBBLE_EXTENDED = 6'h2f;
	// constant answer for reserved fields and suppressed results
	localparam logic [3:0] RESERVED_NIBBLE = 4'h0;
	localparam logic [3:0] INVALID_NIBBLE  = 4'h0;
	// ready messages at the end of self-test
	localparam logic [1:0] READY_MESSAGES = 2'h2;
	// stream word: page, nibble address, nibble
	localparam int WORD_WIDTH = 10;
endpackage : init_seq_pkg
`default_nettype wire

// file: verilog/nibble_stream_if.sv
// valid/ready carrier for the outgoing nibble words
`timescale 1ns/1ps
`default_nettype none
interface nibble_stream_if #(parameter int WIDTH = 10);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface : nibble_stream_if
`default_nettype wire

// file: verilog/two_entry_buffer.sv
// two-entry buffer; the head entry is the output flop
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 10
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	nibble_stream_if.sink         in,
	output var logic             out_valid,
	output var logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	if (WIDTH < 1) begin : g_bad_width
		$error("buffer width must be positive");
	end

	logic             second_valid;
	logic [WIDTH-1:0] second_data;
	logic             push;
	logic             pop;

	// full when both entries hold words; this stalls the sequencer
	assign in.ready = !(out_valid && second_valid);
	assign push     = in.valid && in.ready;
	assign pop      = out_valid && out_ready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (!out_valid || pop) begin
			out_valid <= second_valid || push;
			out_data  <= second_valid ? second_data : in.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			second_valid <= 1'b0;
			second_data  <= '0;
		end else if (push && out_valid && !pop) begin
			second_valid <= 1'b1;
			second_data  <= in.data;
		end else if (pop) begin
			second_valid <= push && second_valid;
			second_data  <= in.data;
		end
	end
endmodule : two_entry_buffer
`default_nettype wire

// file: verilog/init_phase2_sequencer.sv
// phase 2 initialization nibble sequencer with self-test tracking
// ************
// How it works
// ************
// How it works
// - after the first nibble a two-nibble block count goes out, 0x20 normally, 0x30 when extended.
// - nibbles D19 and D20 carry serial byte four or two user nibbles, chosen by the select bit.
// - D33 to D40 carry the four channel 0 results, high nibble before low nibble.
// - D41 to D48 carry the four channel 1 results in the same arrangement.
// - final results appear only when a channel passed before D33, whether on its first try or on a retry.
// - if a channel is still testing when D33 is due, its latest captured values go out.
// - if all retries failed before D33, the last failed attempt's values go out.
// - in asynchronous mode with the extension set, D33 and D34 are sent as zero.
// - reserved fields send fixed constants whatever the registers hold.
// - after start each channel self-tests and repeats a failed test up to the retry limit.
// - when both channels finish, two ready messages go out and both leave phase 3 together.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module init_phase2_sequencer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var logic         s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var logic         s_axi_wready,
	output var logic [1:0]   s_axi_bresp,
	output var logic         s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var logic         s_axi_arready,
	output var logic [31:0]  s_axi_rdata,
	output var logic [1:0]   s_axi_rresp,
	output var logic         s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// self-test engine, same clock
	output var logic [1:0]   selftest_start,
	input  wire logic [1:0]  selftest_attempt_done,
	input  wire logic [1:0]  selftest_attempt_pass,
	input  wire logic [1:0]  selftest_result_valid,
	input  wire logic [31:0] selftest_result_chan0,
	input  wire logic [31:0] selftest_result_chan1,
	output var logic         sensor_ready_msg,
	output var logic         init_phase3_exit,
	// nibble stream to the slot encoder
	output var logic         tx_valid,
	output var logic [1:0]   tx_page,
	output var logic [3:0]   tx_addr,
	output var logic [3:0]   tx_nibble,
	input  wire logic        tx_ready
);
	// ************
	// registers
	// ************
	logic        init_block_count_extend;
	logic        serial_or_user_nibble_select;
	logic        async_mode;
	logic [3:0]  selftest_retry_limit;
	logic [7:0]  user_byte [16];
	logic [7:0]  serial_byte [5];
	logic [7:0]  part_code_byte_zero;
	logic [7:0]  part_code_byte_one;
	logic [31:0] chan_result [2];
	logic [1:0]  chan_done;
	logic [1:0]  chan_pass;
	logic [3:0]  chan_tries [2];
	logic        streaming;
	logic [5:0]  nibble_index;
	logic [1:0]  ready_left;

	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        aw_held;
	logic        w_held;
	logic        do_write;
	logic        start_write;
	logic [31:0] read_word;

	assign do_write    = aw_held && w_held && !s_axi_bvalid;
	assign start_write = do_write && aw_addr == init_seq_pkg::CTRL_OFFSET && w_strb[0]
		&& w_data[init_seq_pkg::CTRL_START_BIT];

	// ************
	// axi4-lite write
	// ************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_held       <= 1'b0;
			aw_addr       <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_held       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_held       <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_held       <= 1'b0;
			w_data       <= init_seq_pkg::DATA_RESET;
			w_strb       <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_held       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_held       <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			// unmapped writes are dropped but answered with slverr
			s_axi_bresp  <= (aw_addr == init_seq_pkg::CTRL_OFFSET
				|| (aw_addr >= init_seq_pkg::USER_BASE_OFFSET
				&& aw_addr <= init_seq_pkg::SERIAL_HI_OFFSET && aw_addr[1:0] == 2'h0))
				? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_block_count_extend      <= 1'b0;
			serial_or_user_nibble_select <= 1'b0;
			async_mode                   <= 1'b0;
			selftest_retry_limit         <= init_seq_pkg::RETRY_LIMIT_RESET;
		end else if (do_write && aw_addr == init_seq_pkg::CTRL_OFFSET && w_strb[0]) begin
			init_block_count_extend      <= w_data[init_seq_pkg::CTRL_EXTEND_BIT];
			serial_or_user_nibble_select <= w_data[init_seq_pkg::CTRL_SELECT_BIT];
			async_mode                   <= w_data[init_seq_pkg::CTRL_ASYNC_BIT];
			selftest_retry_limit         <= w_data[init_seq_pkg::CTRL_RETRY_LSB +: 4];
		end
	end

	// user bytes four to a word, then serial and part code bytes
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_user
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					user_byte[g] <= 8'h00;
				end else if (do_write && w_strb[g % 4]
					&& aw_addr == init_seq_pkg::USER_BASE_OFFSET + 8'(4 * (g / 4))) begin
					user_byte[g] <= w_data[8 * (g % 4) +: 8];
				end
			end
		end
		for (g = 0; g < 4; g++) begin : g_serial
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					serial_byte[g] <= 8'h00;
				end else if (do_write && w_strb[g] && aw_addr == init_seq_pkg::SERIAL_OFFSET) begin
					serial_byte[g] <= w_data[8 * g +: 8];
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_byte[4]      <= 8'h00;
			part_code_byte_zero <= 8'h00;
			part_code_byte_one  <= 8'h00;
		end else if (do_write && aw_addr == init_seq_pkg::SERIAL_HI_OFFSET) begin
			if (w_strb[0]) serial_byte[4] <= w_data[7:0];
			if (w_strb[1]) part_code_byte_zero <= w_data[15:8];
			if (w_strb[2]) part_code_byte_one <= w_data[23:16];
		end
	end

	// ************
	// axi4-lite read
	// ************
	always_comb begin
		read_word = 32'h0000_0000;
		case (s_axi_araddr)
			init_seq_pkg::CTRL_OFFSET:   read_word = {24'h0, selftest_retry_limit, async_mode,
				serial_or_user_nibble_select, init_block_count_extend, 1'b0};
			init_seq_pkg::STATUS_OFFSET: read_word = {18'h0, chan_tries[1], chan_tries[0],
				init_phase3_exit, streaming, chan_pass, chan_done};
			init_seq_pkg::USER_BASE_OFFSET:        read_word = {user_byte[3], user_byte[2],
				user_byte[1], user_byte[0]};
			init_seq_pkg::USER_BASE_OFFSET + 8'h4: read_word = {user_byte[7], user_byte[6],
				user_byte[5], user_byte[4]};
			init_seq_pkg::USER_BASE_OFFSET + 8'h8: read_word = {user_byte[11], user_byte[10],
				user_byte[9], user_byte[8]};
			init_seq_pkg::USER_BASE_OFFSET + 8'hc: read_word = {user_byte[15], user_byte[14],
				user_byte[13], user_byte[12]};
			init_seq_pkg::SERIAL_OFFSET: read_word = {serial_byte[3], serial_byte[2],
				serial_byte[1], serial_byte[0]};
			init_seq_pkg::SERIAL_HI_OFFSET: read_word = {8'h0, part_code_byte_one,
				part_code_byte_zero, serial_byte[4]};
			default: read_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= init_seq_pkg::DATA_RESET;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= read_word;
			s_axi_rresp   <= (s_axi_araddr > init_seq_pkg::SERIAL_HI_OFFSET
				|| s_axi_araddr[1:0] != 2'h0
				|| (s_axi_araddr > init_seq_pkg::STATUS_OFFSET
				&& s_axi_araddr < init_seq_pkg::USER_BASE_OFFSET)) ? 2'h2 : 2'h0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// ************
	// per-channel self-test tracking
	// ************
	logic [31:0] result_in [2];
	assign result_in[0] = selftest_result_chan0;
	assign result_in[1] = selftest_result_chan1;

	generate
		for (g = 0; g < 2; g++) begin : g_chan
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					selftest_start[g] <= 1'b0;
					chan_done[g]      <= 1'b0;
					chan_pass[g]      <= 1'b0;
					chan_tries[g]     <= 4'h0;
				end else if (start_write) begin
					selftest_start[g] <= 1'b1;
					chan_done[g]      <= 1'b0;
					chan_pass[g]      <= 1'b0;
					chan_tries[g]     <= 4'h0;
				end else if (selftest_attempt_done[g] && !chan_done[g]) begin
					if (selftest_attempt_pass[g]) begin
						selftest_start[g] <= 1'b0;
						chan_done[g]      <= 1'b1;
						chan_pass[g]      <= 1'b1;
					end else if (chan_tries[g] >= selftest_retry_limit) begin
						selftest_start[g] <= 1'b0;
						chan_done[g]      <= 1'b1;
					end else begin
						selftest_start[g] <= 1'b1;
						chan_tries[g]     <= chan_tries[g] + 4'h1;
					end
				end else begin
					selftest_start[g] <= 1'b0;
				end
			end

			// latest capture is what field 10 sends; freezes once the channel is done
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					chan_result[g] <= init_seq_pkg::DATA_RESET;
				end else if (selftest_result_valid[g] && !chan_done[g]) begin
					chan_result[g] <= result_in[g];
				end
			end
		end
	endgenerate

	// both channels leave together; two ready messages on alternate cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_phase3_exit <= 1'b0;
			ready_left       <= 2'h0;
			sensor_ready_msg <= 1'b0;
		end else if (start_write) begin
			init_phase3_exit <= 1'b0;
			ready_left       <= 2'h0;
			sensor_ready_msg <= 1'b0;
		end else if (chan_done == 2'b11 && !init_phase3_exit) begin
			init_phase3_exit <= 1'b1;
			ready_left       <= init_seq_pkg::READY_MESSAGES;
			sensor_ready_msg <= 1'b0;
		end else begin
			sensor_ready_msg <= ready_left != 2'h0 && !sensor_ready_msg;
			if (ready_left != 2'h0 && !sensor_ready_msg) ready_left <= ready_left - 2'h1;
		end
	end

	// ************
	// nibble sequencer
	// ************
	nibble_stream_if #(.WIDTH(init_seq_pkg::WORD_WIDTH)) seq_stream ();
	logic [3:0] nibble;
	logic [7:0] block_count;
	logic [7:0] result_byte;
	logic [5:0] last_index;

	assign block_count = init_block_count_extend ? init_seq_pkg::BLOCK_COUNT_EXTENDED
		: init_seq_pkg::BLOCK_COUNT_BASE;
	assign last_index  = init_block_count_extend ? init_seq_pkg::LAST_NIBBLE_EXTENDED
		: init_seq_pkg::LAST_NIBBLE_BASE;
	// results: channel picked by address bit 3, byte by bits 2:1
	assign result_byte = chan_result[nibble_index[3]][8 * (3 - nibble_index[2:1]) +: 8];

	always_comb begin
		nibble = init_seq_pkg::RESERVED_NIBBLE;
		if (nibble_index[5:4] == 2'h2) begin
			nibble = nibble_index[0] ? result_byte[3:0] : result_byte[7:4];
			if (async_mode && init_block_count_extend && nibble_index[3:1] == 3'h0) begin
				nibble = init_seq_pkg::INVALID_NIBBLE;
			end
		end else begin
			case (nibble_index[4:0])
				5'd0:  nibble = user_byte[0][7:4];
				5'd1:  nibble = block_count[7:4];
				5'd2:  nibble = block_count[3:0];
				5'd3:  nibble = user_byte[9][3:0];
				5'd4:  nibble = user_byte[9][7:4];
				5'd5:  nibble = user_byte[10][3:0];
				5'd6:  nibble = user_byte[10][7:4];
				5'd7:  nibble = user_byte[11][3:0];
				5'd8:  nibble = user_byte[11][7:4];
				5'd9:  nibble = user_byte[12][3:0];
				5'd10: nibble = user_byte[12][7:4];
				5'd11: nibble = user_byte[13][3:0];
				5'd12: nibble = user_byte[13][7:4];
				5'd13: nibble = user_byte[14][3:0];
				5'd14: nibble = user_byte[7][3:0];
				5'd15: nibble = user_byte[7][7:4];
				5'd16: nibble = user_byte[8][3:0];
				5'd17: nibble = user_byte[8][7:4];
				5'd18: nibble = serial_or_user_nibble_select ? user_byte[6][7:4]
					: serial_byte[4][7:4];
				5'd19: nibble = serial_or_user_nibble_select ? user_byte[14][7:4]
					: serial_byte[4][3:0];
				5'd20: nibble = serial_byte[3][7:4];
				5'd21: nibble = serial_byte[3][3:0];
				5'd22: nibble = serial_byte[2][7:4];
				5'd23: nibble = serial_byte[2][3:0];
				5'd24: nibble = serial_byte[1][7:4];
				5'd25: nibble = serial_byte[1][3:0];
				5'd26: nibble = serial_byte[0][7:4];
				5'd27: nibble = serial_byte[0][3:0];
				5'd28: nibble = part_code_byte_one[3:0];
				5'd29: nibble = part_code_byte_zero[7:4];
				5'd30: nibble = part_code_byte_zero[3:0];
				5'd31: nibble = user_byte[14][7:4];
				default: nibble = init_seq_pkg::RESERVED_NIBBLE;
			endcase
		end
	end

	// page and address are the index split; the address wraps per page
	assign seq_stream.valid = streaming;
	assign seq_stream.data  = {nibble_index[5:4], nibble_index[3:0], nibble};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			streaming    <= 1'b0;
			nibble_index <= 6'h00;
		end else if (start_write) begin
			streaming    <= 1'b1;
			nibble_index <= 6'h00;
		end else if (streaming && seq_stream.ready) begin
			streaming    <= nibble_index != last_index;
			nibble_index <= nibble_index + 6'h01;
		end
	end

	logic [init_seq_pkg::WORD_WIDTH-1:0] tx_word;
	assign tx_page   = tx_word[9:8];
	assign tx_addr   = tx_word[7:4];
	assign tx_nibble = tx_word[3:0];

	two_entry_buffer #(.WIDTH(init_seq_pkg::WORD_WIDTH)) u_buffer (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in        (seq_stream),
		.out_valid (tx_valid),
		.out_data  (tx_word),
		.out_ready (tx_ready)
	);
endmodule : init_phase2_sequencer
`default_nettype wire

// file: verif/init_seq_checker.sv
// port assertions for the phase 2 nibble sequencer
`timescale 1ns/1ps
`default_nettype none
module init_seq_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [1:0] selftest_start,
	input wire logic       sensor_ready_msg,
	input wire logic       init_phase3_exit,
	input wire logic       tx_valid,
	input wire logic [1:0] tx_page,
	input wire logic [3:0] tx_addr,
	input wire logic [3:0] tx_nibble,
	input wire logic       tx_ready
);
	logic [5:0] last;
	logic       seen;
	wire logic  take = tx_valid && tx_ready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen <= 1'b0;
			last <= 6'h00;
		end else if (take) begin
			seen <= 1'b1;
			last <= {tx_page, tx_addr};
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address taken while busy");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
	tx_hold_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable({tx_page, tx_addr, tx_nibble}))
		else $error("stream word changed while stalled");
	addr_step_a: assert property (
		take && seen |-> {tx_page, tx_addr} == last + 6'h01 || {tx_page, tx_addr} == 6'h00)
		else $error("nibble address out of sequence");
	count_high_a: assert property (
		take && tx_page == 2'h0 && tx_addr == 4'h1 |-> tx_nibble[3:1] == 3'h1)
		else $error("block count high nibble wrong");
	count_low_a: assert property (
		take && tx_page == 2'h0 && tx_addr == 4'h2 |-> tx_nibble == 4'h0)
		else $error("block count low nibble wrong");
	ready_pair_a: assert property (
		$rose(init_phase3_exit) |=> sensor_ready_msg ##1 !sensor_ready_msg
		##1 sensor_ready_msg ##1 !sensor_ready_msg) else $error("ready messages wrong");
	start_pulse_a: assert property (selftest_start[1] |=> !selftest_start[1])
		else $error("self-test start longer than one cycle");
endmodule : init_seq_checker
bind init_phase2_sequencer init_seq_checker init_seq_checker_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.selftest_start(selftest_start), .sensor_ready_msg(sensor_ready_msg),
	.init_phase3_exit(init_phase3_exit), .tx_valid(tx_valid), .tx_page(tx_page),
	.tx_addr(tx_addr), .tx_nibble(tx_nibble), .tx_ready(tx_ready)
);
`default_nettype wire

// file: verif/nibble_sink_model.sv
// receiving end of the nibble stream, optionally stalling
`timescale 1ns/1ps
`default_nettype none
module nibble_sink_model (
	input  wire logic       aclk,
	input  wire logic       stall,
	input  wire logic       tx_valid,
	input  wire logic [1:0] tx_page,
	input  wire logic [3:0] tx_addr,
	input  wire logic [3:0] tx_nibble,
	output var logic        tx_ready
);
	logic [9:0] got [$];
	logic [3:0] cyc;
	initial begin
		cyc = 4'h0;
		tx_ready = 1'b0;
	end
	// one take in sixteen keeps both buffer entries full and the sequencer halted
	always @(posedge aclk) begin
		cyc <= cyc + 4'h1;
		tx_ready <= !stall || cyc == 4'hf;
		if (tx_valid && tx_ready)
			got.push_back({tx_page, tx_addr, tx_nibble});
	end
endmodule : nibble_sink_model
`default_nettype wire

// file: verif/psi5_init_phase2_data_sequencer_tb_top.sv
// self-checking bench for the phase 2 nibble sequencer
`timescale 1ns/1ps
`default_nettype none
module psi5_init_phase2_data_sequencer_tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stall;
	logic        awready, wready, bvalid, arready, rvalid, ready_msg, exit_lvl;
	logic        tx_valid, tx_ready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, res0, res1, er0, er1;
	logic [1:0]  bresp, rresp, st_start, st_done, st_pass, st_rv, tx_page, pass_cfg;
	logic [3:0]  tx_addr, tx_nibble;
	logic [7:0]  ub [16];
	logic [7:0]  sn [5];
	logic [7:0]  pn [2];
	int          att [2], cnt [2], dly, n_rdy, ticks, failures, checks_done;

	init_phase2_sequencer init_phase2_sequencer_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.selftest_start(st_start), .selftest_attempt_done(st_done),
		.selftest_attempt_pass(st_pass), .selftest_result_valid(st_rv),
		.selftest_result_chan0(res0), .selftest_result_chan1(res1),
		.sensor_ready_msg(ready_msg), .init_phase3_exit(exit_lvl), .tx_valid(tx_valid),
		.tx_page(tx_page), .tx_addr(tx_addr), .tx_nibble(tx_nibble), .tx_ready(tx_ready)
	);
	nibble_sink_model nibble_sink_model_inst (
		.aclk(aclk), .stall(stall), .tx_valid(tx_valid), .tx_page(tx_page),
		.tx_addr(tx_addr), .tx_nibble(tx_nibble), .tx_ready(tx_ready)
	);

	// ****************
	// self-test engine
	// ****************
	function automatic logic [31:0] rv(int c, int a);
		return {8'h90 + 8'(16 * c + a), 8'h35 + 8'(a), 8'h6c + 8'(c), 8'hd1 + 8'(a)};
	endfunction : rv
	always @(posedge aclk) begin
		for (int c = 0; c < 2; c++) begin
			st_done[c] <= 1'b0;
			st_rv[c] <= 1'b0;
			if (st_start[c]) begin
				att[c] <= att[c] + 1;
				cnt[c] <= 1;
			end else if (cnt[c] != 0) begin
				cnt[c] <= (cnt[c] == dly) ? 0 : cnt[c] + 1;
				st_rv[c] <= cnt[c] == 3;
				st_done[c] <= cnt[c] == dly;
				st_pass[c] <= pass_cfg[c];
			end
		end
		res0 <= rv(0, att[0]);
		res1 <= rv(1, att[1]);
		if (ready_msg)
			n_rdy <= n_rdy + 1;
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			failures++;
			conclude();
		end
	end

	// ***********
	// bench tasks
	// ***********
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd
	function automatic logic [3:0] en(int i, logic e, logic s, logic y);
		logic [7:0] b;
		logic       h;
		h = i[0];
		if (i == 1) begin b = ub[0]; h = 1'b1; end
		else if (i <= 3) return (i == 2) ? {3'h1, e} : 4'h0;
		else if (i <= 14) b = ub[9 + (i - 4) / 2];
		else if (i <= 18) begin b = ub[7 + (i - 15) / 2]; h = !i[0]; end
		else if (i <= 20) begin b = s ? ub[i == 19 ? 6 : 14] : sn[4]; h = s || i == 19; end
		else if (i <= 28) b = sn[3 - (i - 21) / 2];
		else if (i <= 31) begin b = (i == 29) ? pn[1] : pn[0]; h = i == 30; end
		else if (i == 32) begin b = ub[14]; h = 1'b1; end
		else if (y && e && i <= 34) return 4'h0;
		else b = 8'(((i <= 40) ? er0 : er1) >> (8 * (3 - ((i - 33) % 8) / 2)));
		return h ? b[7:4] : b[3:0];
	endfunction : en

	// *********
	// scenarios
	// *********
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rd(8'h00, d, r);
		chk(d, 32'h20);
		chk(32'(r), 32'h0);
		rd(8'h04, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'h0);
		rd(8'h40, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'h2);
		wr(8'h44, 32'hffff_ffff, r);
		chk(32'(r), 32'h2);
		for (int w = 0; w < 4; w++)
			wr(8'h10 + 8'(4 * w), {ub[4*w+3], ub[4*w+2], ub[4*w+1], ub[4*w]}, r);
		wr(8'h20, {sn[3], sn[2], sn[1], sn[0]}, r);
		wr(8'h24, {8'h00, pn[1], pn[0], sn[4]}, r);
		rd(8'h24, d, r);
		chk(d, {8'h00, pn[1], pn[0], sn[4]});
	endtask : t_regs
	task automatic run(input logic e, s, y, st, input int d, input logic [1:0] p);
		logic [31:0] v;
		logic [1:0]  r;
		int          n;
		n = e ? 48 : 32;
		dly = d;
		pass_cfg = p;
		stall <= st;
		att = '{0, 0};
		n_rdy = 0;
		nibble_sink_model_inst.got.delete();
		wr(8'h00, {24'h0, 4'h2, y, s, e, 1'b1}, r);
		while (nibble_sink_model_inst.got.size() < n || !exit_lvl)
			@(posedge aclk);
		repeat (4) @(posedge aclk);
		er0 = rv(0, att[0]);
		er1 = rv(1, att[1]);
		for (int i = 0; i < n; i++)
			chk(32'(nibble_sink_model_inst.got[i]), 32'({2'(i / 16), 4'(i % 16),
				en(i + 1, e, s, y)}));
		chk(n_rdy, 2);
		chk(att[0] + 16 * att[1], (p[0] ? 1 : 3) + 16 * (p[1] ? 1 : 3));
		rd(8'h04, v, r);
		chk(v & ~32'h10, {18'h0, p[1] ? 4'h0 : 4'h2, p[0] ? 4'h0 : 4'h2, 2'h2, p, 2'h3});
	endtask : run

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, stall} = '0;
		{awaddr, araddr, wdata, res0, res1, st_done, st_pass, st_rv} = '0;
		att = '{0, 0};
		cnt = '{0, 0};
		dly = 6;
		pass_cfg = 2'h0;
		for (int n = 0; n < 16; n++)
			ub[n] = {4'(n), 4'(15 - n)};
		sn = '{8'h31, 8'h42, 8'h53, 8'h64, 8'h75};
		pn = '{8'hc9, 8'hb6};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		run(1'b0, 1'b0, 1'b0, 1'b0, 6, 2'b01);
		run(1'b1, 1'b1, 1'b0, 1'b1, 6, 2'b01);
		run(1'b1, 1'b0, 1'b1, 1'b0, 120, 2'b11);
		conclude();
	end
endmodule : psi5_init_phase2_data_sequencer_tb_top
`default_nettype wire
